// *** common/ssp_pkg.sv ***
package ssp_pkg;
   // byte addresses of the register words
   localparam logic [7:0] ADDR_ROLE = 8'h00;
   localparam logic [7:0] ADDR_MODE = 8'h04;
   localparam logic [7:0] ADDR_ORDER = 8'h08;
   localparam logic [7:0] ADDR_ENABLE = 8'h0c;
   localparam logic [7:0] ADDR_FLAGS = 8'h10;
   localparam logic [7:0] ADDR_RXBUF = 8'h14;
   localparam logic [7:0] ADDR_TXBUF = 8'h18;
   localparam logic [7:0] ADDR_HALT = 8'h1c;
   // role_pin_control
   localparam int ROLE_MASTER = 7;
   localparam int ROLE_SCLK_PIN = 2;
   localparam int ROLE_CS_HI = 1;
   localparam int ROLE_CS_LO = 0;
   localparam logic [7:0] ROLE_MASK = 8'h87;
   // mode_control
   localparam int MODE_FOUR_LINE = 6;
   localparam logic [7:0] MODE_MASK = 8'h40;
   // order_rate_control
   localparam int ORDER_MSB = 7;
   localparam logic [7:0] ORDER_MASK = 8'h87;
   localparam logic [7:0] ORDER_RST = 8'h03;
   // enable_control; bits 4..0 pair with the flag bits
   localparam int ENA_TX = 7;
   localparam int ENA_RX = 6;
   localparam logic [7:0] ENABLE_MASK = 8'hdf;
   // event_flags
   localparam int FLG_OVR = 4;
   localparam int FLG_TEND = 3;
   localparam int FLG_TDRE = 2;
   localparam int FLG_RXF = 1;
   localparam int FLG_CONF = 0;
   localparam int NUM_FLAGS = 5;
   localparam logic [NUM_FLAGS-1:0] FLAGS_RST = 5'h04;
   // clock_halt_control
   localparam int HALT_CLOCK_ON = 0;
   // chip select pin use: 10 input, 11 output
   localparam logic [1:0] CS_AS_INPUT = 2'h2;
   localparam logic [1:0] CS_AS_OUTPUT = 2'h3;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [7:0] IDLE_FILL = 8'hff;
   localparam logic [2:0] LAST_BIT = 3'h7;
   // rate: half period = HALF_BASE << rate, 011 gives 16 + 16 = 32 cycles
   localparam int CNT_W = 9;
   localparam logic [CNT_W-1:0] HALF_BASE = 9'h002;
   localparam logic [CNT_W-1:0] CNT_ONE = 9'h001;
   typedef enum logic [1:0] {ENG_IDLE, ENG_LOW, ENG_HIGH} ssp_eng_t;
endpackage : ssp_pkg

// *** hdl/ssp_ahb_slave.sv ***
`timescale 1ns/1ns
module ssp_ahb_slave
   import ssp_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   // bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // register side
   output logic wr_pulse,
   output logic rd_pulse,
   output logic [7:0] acc_addr,
   output logic [7:0] wr_data,
   input wire logic [7:0] rd_data
);
   logic busy_q, busy_d;
   logic write_q, write_d;
   logic [7:0] addr_q, addr_d;
   logic ready_q, ready_d;
   logic [31:0] rdata_q, rdata_d;
   logic accept;

   always_comb
   begin
      accept = hsel && htrans[1] && hready && !busy_q;
      busy_d = accept;
      ready_d = !accept;
      write_d = accept ? hwrite : write_q;
      // words beyond the register block decode as unmapped
      addr_d = accept ? ((haddr[31:8] == '0) ? haddr[7:0] : 8'hff) : addr_q;
      rdata_d = rdata_q;
      if (busy_q && !write_q)
         rdata_d = {24'h000000, rd_data};
      wr_pulse = busy_q && write_q;
      rd_pulse = busy_q && !write_q;
      acc_addr = addr_q;
      wr_data = hwdata[7:0];
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         busy_q <= 1'b0;
         write_q <= 1'b0;
         addr_q <= 8'h00;
         ready_q <= 1'b1;
         rdata_q <= 32'h00000000;
      end
      else if (ce)
      begin
         busy_q <= busy_d;
         write_q <= write_d;
         addr_q <= addr_d;
         ready_q <= ready_d;
         rdata_q <= rdata_d;
      end
   end

   assign hreadyout = ready_q;
   assign hrdata = rdata_q;
   assign hresp = 1'b0;
endmodule : ssp_ahb_slave

// *** hdl/ssp_rate_div.sv ***
`timescale 1ns/1ns
module ssp_rate_div
   import ssp_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   // control
   input wire logic run,
   input wire logic [2:0] rate_sel,
   // one pulse per half serial clock
   output logic half_tick
);
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic [CNT_W-1:0] reload;

   always_comb
   begin
      reload = (HALF_BASE << rate_sel) - CNT_ONE;
      half_tick = run && (cnt_q == '0);
      if (!run || cnt_q == '0)
         cnt_d = reload;
      else
         cnt_d = cnt_q - CNT_ONE;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         cnt_q <= '0;
      else if (ce)
         cnt_q <= cnt_d;
   end
endmodule : ssp_rate_div

// *** hdl/ssp_top.sv ***
`timescale 1ns/1ns
module ssp_top
   import ssp_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // serial clock pin
   input wire logic serial_clock_pin_i,
   output logic serial_clock_pin_o,
   output logic serial_clock_pin_oe,
   // chip select pin
   input wire logic chip_select_n_pin_i,
   output logic chip_select_n_pin_o,
   output logic chip_select_n_pin_oe,
   // data pins
   input wire logic first_data_pin_i,
   output logic first_data_pin_o,
   output logic first_data_pin_oe,
   input wire logic second_data_pin_i,
   output logic second_data_pin_o,
   output logic second_data_pin_oe,
   // interrupt requests
   output logic tx_buffer_empty_irq,
   output logic tx_end_irq,
   output logic rx_full_irq,
   output logic overrun_irq,
   output logic conflict_irq
);
   logic [7:0] role_q, role_d, mode_q, mode_d, order_q, order_d, enable_q, enable_d;
   logic [NUM_FLAGS-1:0] flags_q, flags_d, seen_q, seen_d, irq_q, irq_d;
   logic [7:0] rxbuf_q, rxbuf_d, txbuf_q, txbuf_d, shift_q, shift_d;
   logic clk_on_q, clk_on_d;
   ssp_eng_t eng_q, eng_d;
   logic [2:0] bit_q, bit_d;
   logic full_q, full_d, rx_bit_q, rx_bit_d, phase_q, phase_d, sclk_prev_q;
   logic sclk_q, sclk_d, cs_q, cs_d;
   logic sclk_oe_q, sclk_oe_d, cs_oe_q, cs_oe_d;
   logic d1_q, d1_d, d1_oe_q, d1_oe_d, d2_q, d2_d, d2_oe_q, d2_oe_d;
   logic wr_pulse, rd_pulse, half_tick;
   logic [7:0] acc_addr, wr_data, rd_data;
   logic master, active, msb, serial_in, rise, fall, start_ok, byte_done, load, conflict;
   logic [7:0] done_byte;

   // register index decode shared by read and write paths
   function automatic logic hit(input logic [7:0] a, input logic [7:0] base);
      hit = (a == base);
   endfunction : hit

   // bit reversal for msb-first loads and stores
   function automatic logic [7:0] rev8(input logic [7:0] v);
      logic [7:0] r;
      r = '0;
      for (int i = 0; i < 8; i++)
         r[i] = v[7 - i];
      rev8 = r;
   endfunction : rev8

   ssp_ahb_slave u_bus (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hready(hready),
      .hwdata(hwdata),
      .hreadyout(hreadyout),
      .hrdata(hrdata),
      .hresp(hresp),
      .wr_pulse(wr_pulse),
      .rd_pulse(rd_pulse),
      .acc_addr(acc_addr),
      .wr_data(wr_data),
      .rd_data(rd_data)
   );

   ssp_rate_div u_div (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .run(eng_q != ENG_IDLE),
      .rate_sel(order_q[2:0]),
      .half_tick(half_tick)
   );

   // read mux; shifter deliberately absent
   always_comb
   begin
      rd_data = 8'h00;
      if (hit(acc_addr, ADDR_ROLE))
         rd_data = role_q;
      else if (hit(acc_addr, ADDR_MODE))
         rd_data = mode_q;
      else if (hit(acc_addr, ADDR_ORDER))
         rd_data = order_q;
      else if (hit(acc_addr, ADDR_ENABLE))
         rd_data = enable_q;
      else if (hit(acc_addr, ADDR_FLAGS))
         rd_data = {3'h0, flags_q};
      else if (hit(acc_addr, ADDR_RXBUF))
         rd_data = rxbuf_q;
      else if (hit(acc_addr, ADDR_TXBUF))
         rd_data = txbuf_q;
      else if (hit(acc_addr, ADDR_HALT))
         rd_data = {7'h00, clk_on_q};
   end

   always_comb
   begin
      role_d = role_q;
      mode_d = mode_q;
      order_d = order_q;
      enable_d = enable_q;
      flags_d = flags_q;
      seen_d = seen_q;
      rxbuf_d = rxbuf_q;
      txbuf_d = txbuf_q;
      clk_on_d = clk_on_q;
      eng_d = eng_q;
      bit_d = bit_q;
      full_d = full_q;
      rx_bit_d = rx_bit_q;
      phase_d = phase_q;
      shift_d = shift_q;
      sclk_d = sclk_q;
      cs_d = cs_q;
      byte_done = 1'b0;
      load = 1'b0;
      done_byte = 8'h00;
      master = role_q[ROLE_MASTER];
      msb = order_q[ORDER_MSB];
      active = clk_on_q && mode_q[MODE_FOUR_LINE];
      serial_in = master ? first_data_pin_i : second_data_pin_i;
      rise = serial_clock_pin_i && !sclk_prev_q;
      fall = !serial_clock_pin_i && sclk_prev_q;
      // overrun halts master transmit until cleared
      start_ok = !flags_q[FLG_OVR] && ((enable_q[ENA_TX] && !flags_q[FLG_TDRE])
                 || (!enable_q[ENA_TX] && enable_q[ENA_RX] && !flags_q[FLG_RXF]));
      conflict = active && master && role_q[ROLE_CS_HI:ROLE_CS_LO] == CS_AS_INPUT && !chip_select_n_pin_i;

      // software side
      if (wr_pulse)
      begin
         if (hit(acc_addr, ADDR_ROLE))
            role_d = wr_data & ROLE_MASK;
         if (hit(acc_addr, ADDR_MODE))
            mode_d = wr_data & MODE_MASK;
         if (hit(acc_addr, ADDR_ORDER))
            order_d = wr_data & ORDER_MASK;
         if (hit(acc_addr, ADDR_ENABLE))
            enable_d = wr_data & ENABLE_MASK;
         if (hit(acc_addr, ADDR_HALT))
            clk_on_d = wr_data[HALT_CLOCK_ON];
         if (hit(acc_addr, ADDR_FLAGS))
         begin
            // through this register a flag clears only when written 0 after being read as 1
            flags_d = flags_q & ~(seen_q & ~wr_data[NUM_FLAGS-1:0]);
            seen_d = '0;
         end
      end
      if (rd_pulse && hit(acc_addr, ADDR_FLAGS))
         seen_d = flags_q;
      if (rd_pulse && hit(acc_addr, ADDR_RXBUF))
         flags_d[FLG_RXF] = 1'b0;

      // engine
      if (!active)
      begin
         eng_d = ENG_IDLE;
         bit_d = '0;
         full_d = 1'b0;
         phase_d = 1'b0;
         sclk_d = 1'b0;
         cs_d = 1'b1;
      end
      else if (master)
      begin
         full_d = 1'b0;
         unique case (eng_q)
            ENG_IDLE:
               if (start_ok)
               begin
                  load = 1'b1;
                  cs_d = 1'b0;
                  eng_d = ENG_LOW;
               end
               else
                  cs_d = 1'b1;
            ENG_LOW:
               if (half_tick)
               begin
                  sclk_d = 1'b1;
                  rx_bit_d = serial_in;
                  eng_d = ENG_HIGH;
               end
            ENG_HIGH:
               if (half_tick)
               begin
                  sclk_d = 1'b0;
                  shift_d = {rx_bit_q, shift_q[7:1]};
                  bit_d = bit_q + 3'h1;
                  eng_d = ENG_LOW;
                  if (bit_q == LAST_BIT)
                  begin
                     byte_done = 1'b1;
                     eng_d = ENG_IDLE; // select stays low if next byte is queued
                  end
               end
         endcase
      end
      else
      begin
         eng_d = ENG_IDLE;
         sclk_d = 1'b0;
         cs_d = 1'b1;
         if (chip_select_n_pin_i)
         begin
            bit_d = '0;
            full_d = 1'b0;
            phase_d = 1'b0;
         end
         else
         begin
            if (!full_q && bit_q == '0 && !phase_q && enable_q[ENA_TX] && !flags_q[FLG_TDRE])
            begin
               load = 1'b1;
               full_d = 1'b1;
            end
            if (rise)
            begin
               rx_bit_d = serial_in;
               phase_d = 1'b1;
            end
            else if (fall && phase_q)
            begin
               phase_d = 1'b0;
               shift_d = {rx_bit_q, shift_q[7:1]};
               bit_d = bit_q + 3'h1;
               if (bit_q == LAST_BIT)
               begin
                  byte_done = 1'b1;
                  full_d = 1'b0;
               end
            end
         end
      end

      if (load)
      begin
         if (enable_q[ENA_TX] && !flags_q[FLG_TDRE])
         begin
            shift_d = msb ? rev8(txbuf_q) : txbuf_q;
            flags_d[FLG_TDRE] = 1'b1;
         end
         else
            shift_d = IDLE_FILL;
      end

      if (byte_done)
      begin
         done_byte = {rx_bit_q, shift_q[7:1]};
         if (enable_q[ENA_RX] && !flags_q[FLG_OVR])
         begin
            if (flags_q[FLG_RXF])
               flags_d[FLG_OVR] = 1'b1;
            else
            begin
               rxbuf_d = msb ? rev8(done_byte) : done_byte;
               flags_d[FLG_RXF] = 1'b1;
            end
         end
         if (enable_q[ENA_TX] && flags_q[FLG_TDRE])
            flags_d[FLG_TEND] = 1'b1;
      end

      // writing the transmit buffer queues a byte behind the shifting one
      if (wr_pulse && hit(acc_addr, ADDR_TXBUF))
      begin
         txbuf_d = wr_data;
         flags_d[FLG_TDRE] = 1'b0;
         flags_d[FLG_TEND] = 1'b0;
      end

      if (conflict)
      begin
         flags_d[FLG_CONF] = 1'b1;
         role_d[ROLE_MASTER] = 1'b0;
         eng_d = ENG_IDLE;
         bit_d = '0;
         cs_d = 1'b1;
         sclk_d = 1'b0;
      end

      // pin drivers
      sclk_oe_d = active && role_d[ROLE_MASTER] && role_q[ROLE_SCLK_PIN];
      cs_oe_d = active && role_d[ROLE_MASTER] && role_q[ROLE_CS_HI:ROLE_CS_LO] == CS_AS_OUTPUT;
      d2_d = shift_d[0];
      d2_oe_d = active && role_d[ROLE_MASTER] && enable_q[ENA_TX];
      d1_d = shift_d[0];
      d1_oe_d = active && !role_d[ROLE_MASTER] && enable_q[ENA_TX] && !chip_select_n_pin_i;

      for (int i = 0; i < NUM_FLAGS; i++)
         irq_d[i] = flags_d[i] && enable_q[i];
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         role_q <= BYTE_RST;
         mode_q <= BYTE_RST;
         order_q <= ORDER_RST;
         enable_q <= BYTE_RST;
         flags_q <= FLAGS_RST;
         seen_q <= '0;
         rxbuf_q <= BYTE_RST;
         txbuf_q <= BYTE_RST;
         clk_on_q <= 1'b0;
         eng_q <= ENG_IDLE;
         bit_q <= '0;
         full_q <= 1'b0;
         rx_bit_q <= 1'b0;
         phase_q <= 1'b0;
         shift_q <= BYTE_RST;
         sclk_prev_q <= 1'b0;
         sclk_q <= 1'b0;
         cs_q <= 1'b1;
         sclk_oe_q <= 1'b0;
         cs_oe_q <= 1'b0;
         d1_q <= 1'b0;
         d1_oe_q <= 1'b0;
         d2_q <= 1'b0;
         d2_oe_q <= 1'b0;
         irq_q <= '0;
      end
      else if (ce)
      begin
         role_q <= role_d;
         mode_q <= mode_d;
         order_q <= order_d;
         enable_q <= enable_d;
         flags_q <= flags_d;
         seen_q <= seen_d;
         rxbuf_q <= rxbuf_d;
         txbuf_q <= txbuf_d;
         clk_on_q <= clk_on_d;
         eng_q <= eng_d;
         bit_q <= bit_d;
         full_q <= full_d;
         rx_bit_q <= rx_bit_d;
         phase_q <= phase_d;
         shift_q <= shift_d;
         sclk_prev_q <= serial_clock_pin_i;
         sclk_q <= sclk_d;
         cs_q <= cs_d;
         sclk_oe_q <= sclk_oe_d;
         cs_oe_q <= cs_oe_d;
         d1_q <= d1_d;
         d1_oe_q <= d1_oe_d;
         d2_q <= d2_d;
         d2_oe_q <= d2_oe_d;
         irq_q <= irq_d;
      end
   end

   assign serial_clock_pin_o = sclk_q;
   assign serial_clock_pin_oe = sclk_oe_q;
   assign chip_select_n_pin_o = cs_q;
   assign chip_select_n_pin_oe = cs_oe_q;
   assign first_data_pin_o = d1_q;
   assign first_data_pin_oe = d1_oe_q;
   assign second_data_pin_o = d2_q;
   assign second_data_pin_oe = d2_oe_q;
   assign overrun_irq = irq_q[FLG_OVR];
   assign tx_end_irq = irq_q[FLG_TEND];
   assign tx_buffer_empty_irq = irq_q[FLG_TDRE];
   assign rx_full_irq = irq_q[FLG_RXF];
   assign conflict_irq = irq_q[FLG_CONF];
endmodule : ssp_top

// *** sim/ssp_peer_slave.sv ***
`timescale 1ns/1ns
module ssp_peer_slave
(
   // link
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   output logic miso,
   // test side
   input wire logic msb_first,
   input wire logic [7:0] reply,
   output logic [7:0] got,
   output int nbytes
);
   logic [7:0] sh = 8'h00;
   logic [7:0] rx = 8'h00;
   int cnt = 0;
   initial
   begin
      miso = 1'b0;
      got = 8'h00;
      nbytes = 0;
   end
   // sample on rising edge while selected
   always @(posedge sclk)
      if (!cs_n)
      begin
         rx = msb_first ? {rx[6:0], mosi} : {mosi, rx[7:1]};
         cnt = (cnt + 1) % 8;
         if (cnt == 0)
         begin
            got = rx;
            nbytes++;
         end
      end
   // next bit on select or falling edge; released line shows the inverse
   always @(cs_n or negedge sclk)
      if (cs_n)
         miso = ~miso;
      else
      begin
         if (cnt == 0)
            sh = reply;
         miso = msb_first ? sh[7 - cnt] : sh[cnt];
      end
endmodule : ssp_peer_slave

// *** sim/ssp_top_props.sv ***
`timescale 1ns/1ns
module ssp_top_props
   import ssp_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // bus
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic hresp,
   // pins
   input wire logic serial_clock_pin_o,
   input wire logic serial_clock_pin_oe,
   input wire logic chip_select_n_pin_o,
   input wire logic chip_select_n_pin_oe,
   input wire logic first_data_pin_oe,
   input wire logic second_data_pin_oe,
   input wire logic conflict_irq
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic [11:0] hi_cnt_q;
   logic [11:0] lo_cnt_q;
   logic [4:0] rise_cnt_q;
   logic sclk_q;
   // cycles high, cycles selected, rising edges per select window
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hi_cnt_q <= 12'h000;
         lo_cnt_q <= 12'h000;
         rise_cnt_q <= 5'h00;
         sclk_q <= 1'b0;
      end
      else
      begin
         sclk_q <= serial_clock_pin_o;
         hi_cnt_q <= serial_clock_pin_o ? hi_cnt_q + 12'h001 : 12'h000;
         lo_cnt_q <= chip_select_n_pin_o ? 12'h000 : lo_cnt_q + 12'h001;
         rise_cnt_q <= chip_select_n_pin_o ? 5'h00 : rise_cnt_q + 5'(serial_clock_pin_o && !sclk_q);
      end
   end
   sequence acc_s;
      hsel && htrans[1] && hready;
   endsequence
   sequence wait_s;
      !hreadyout ##1 hreadyout;
   endsequence
   bus_wait_a: assert property (acc_s |=> wait_s) else $error("bus wait state wrong");
   resp_okay_a: assert property (hresp == 1'b0) else $error("response not okay");
   upper_zero_a: assert property (hreadyout |-> hrdata[31:8] == 24'h000000) else $error("read data wider than byte");
   pin_owner_a: assert property (!(first_data_pin_oe && second_data_pin_oe)) else $error("both data pins driven");
   half_period_a: assert property ($fell(serial_clock_pin_o) |-> hi_cnt_q == 12'd16) else $error("clock high time wrong");
   byte_frame_a: assert property ($rose(chip_select_n_pin_o) && chip_select_n_pin_oe |-> lo_cnt_q >= 12'd256)
      else $error("select window too short");
   edge_count_a: assert property ($rose(chip_select_n_pin_o) && chip_select_n_pin_oe |->
      rise_cnt_q[2:0] == 3'h0 && rise_cnt_q != 5'h00) else $error("clock edges per window not whole bytes");
   idle_clock_a: assert property (chip_select_n_pin_o && chip_select_n_pin_oe |-> !serial_clock_pin_o)
      else $error("clock moves while deselected");
   conflict_drop_a: assert property ($rose(conflict_irq) |-> !serial_clock_pin_oe && !second_data_pin_oe)
      else $error("still master after conflict");
endmodule : ssp_top_props
bind ssp_top ssp_top_props ssp_top_props_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
   .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
   .serial_clock_pin_o(serial_clock_pin_o), .serial_clock_pin_oe(serial_clock_pin_oe),
   .chip_select_n_pin_o(chip_select_n_pin_o), .chip_select_n_pin_oe(chip_select_n_pin_oe),
   .first_data_pin_oe(first_data_pin_oe), .second_data_pin_oe(second_data_pin_oe), .conflict_irq(conflict_irq));

// *** sim/ssp_top_tb.sv ***
`timescale 1ns/1ns
module ssp_top_tb;
   import ssp_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic cs_drv = 1'b1;
   logic sclk_drv = 1'b0;
   logic mosi_drv = 1'b0;
   logic [7:0] srx;
   logic msb = 1'b1;
   logic [7:0] reply = 8'h3c;
   logic [7:0] r;
   logic hreadyout, hresp, miso, sclk_o, sclk_oe, cs_o, cs_oe, d1_o, d1_oe, d2_o, d2_oe;
   logic txe_irq, tend_irq, rxf_irq, ovr_irq, conf_irq;
   logic [31:0] hrdata;
   logic [7:0] got;
   int nbytes;
   int miscompares = 0;
   int n_checks = 0;
   logic [7:0] ra [9] = '{ADDR_ROLE, ADDR_MODE, ADDR_ORDER, ADDR_ENABLE, ADDR_FLAGS, ADDR_RXBUF, ADDR_TXBUF,
      ADDR_HALT, 8'h20};
   logic [7:0] rv [9] = '{8'h00, 8'h00, ORDER_RST, 8'h00, {3'h0, FLAGS_RST}, 8'h00, 8'h00, 8'h00, 8'h00};
   wire sclk_w = sclk_oe ? sclk_o : sclk_drv;
   wire cs_w = cs_oe ? cs_o : cs_drv;
   wire mosi_w = d2_oe ? d2_o : (cs_drv ? ~d2_o : mosi_drv);
   wire miso_w = d1_oe ? d1_o : miso;
   initial
   begin
      forever #4 hclk = ~hclk;
   end
   ssp_top ssp_top_i (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .serial_clock_pin_i(sclk_w), .serial_clock_pin_o(sclk_o), .serial_clock_pin_oe(sclk_oe),
      .chip_select_n_pin_i(cs_w), .chip_select_n_pin_o(cs_o), .chip_select_n_pin_oe(cs_oe),
      .first_data_pin_i(miso_w), .first_data_pin_o(d1_o), .first_data_pin_oe(d1_oe),
      .second_data_pin_i(mosi_w), .second_data_pin_o(d2_o), .second_data_pin_oe(d2_oe),
      .tx_buffer_empty_irq(txe_irq), .tx_end_irq(tend_irq), .rx_full_irq(rxf_irq), .overrun_irq(ovr_irq),
      .conflict_irq(conf_irq));
   ssp_peer_slave ssp_peer_slave_i (.sclk(sclk_w), .cs_n(cs_w), .mosi(mosi_w), .miso(miso), .msb_first(msb),
      .reply(reply), .got(got), .nbytes(nbytes));
   task close_out;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : close_out
   task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task bus(input logic [7:0] a, input logic w, input logic [7:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h000000, d};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      r = hrdata[7:0];
   endtask : bus
   task rc(input logic [7:0] a, input logic [7:0] exp, input string nm);
      bus(a, 1'b0, 8'h00);
      chk(nm, r, exp);
   endtask : rc
   task wait_bytes(input int n);
      while (nbytes < n) @(posedge hclk);
   endtask : wait_bytes
   // bench as master peer: caller holds select low, mode 0, lsb first
   task sbyte(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 0; i < 8; i++)
      begin
         mosi_drv <= tx[i];
         repeat (4) @(posedge hclk);
         sclk_drv <= 1'b1;
         rx[i] = miso_w;
         repeat (4) @(posedge hclk);
         sclk_drv <= 1'b0;
      end
   endtask : sbyte
   initial
   begin
      repeat (20000) @(posedge hclk);
      miscompares++;
      close_out();
   end
   initial
   begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      for (int i = 0; i < 9; i++)
         rc(ra[i], rv[i], "reset value");
      chk("txe irq masked", {7'h0, txe_irq}, 8'h00);
      bus(ADDR_RXBUF, 1'b1, 8'h5a);
      rc(ADDR_RXBUF, 8'h00, "rx buffer write");
      bus(ADDR_TXBUF, 1'b1, 8'ha5);
      rc(ADDR_TXBUF, 8'ha5, "tx buffer");
      bus(ADDR_ROLE, 1'b1, 8'h87);
      bus(ADDR_MODE, 1'b1, 8'h40);
      bus(ADDR_ORDER, 1'b1, 8'h83);
      bus(ADDR_ENABLE, 1'b1, 8'hdf);
      rc(ADDR_ROLE, 8'h87, "role");
      repeat (40) @(posedge hclk);
      chk("standby select", {7'h0, cs_o}, 8'h01);
      $display("test registers done");
      bus(ADDR_HALT, 1'b1, 8'h01);
      while (cs_w !== 1'b0) @(posedge hclk);
      reply <= 8'hc3;
      repeat (4) @(posedge hclk);
      chk("txe irq", {7'h0, txe_irq}, 8'h01);
      bus(ADDR_TXBUF, 1'b1, 8'h96);
      wait_bytes(1);
      chk("byte 1 sent", got, 8'ha5);
      repeat (24) @(posedge hclk);
      chk("rxf irq", {7'h0, rxf_irq}, 8'h01);
      rc(ADDR_RXBUF, 8'h3c, "byte 1 received");
      chk("rxf irq cleared", {7'h0, rxf_irq}, 8'h00);
      wait_bytes(2);
      chk("byte 2 sent", got, 8'h96);
      repeat (24) @(posedge hclk);
      chk("select released", {7'h0, cs_o}, 8'h01);
      rc(ADDR_FLAGS, 8'h0e, "flags after pair");
      $display("test back to back done");
      reply <= 8'h77;
      bus(ADDR_TXBUF, 1'b1, 8'he1);
      wait_bytes(3);
      repeat (24) @(posedge hclk);
      chk("ovr irq", {7'h0, ovr_irq}, 8'h01);
      rc(ADDR_RXBUF, 8'hc3, "kept byte");
      bus(ADDR_TXBUF, 1'b1, 8'h48);
      repeat (300) @(posedge hclk);
      chk("halted count", nbytes[7:0], 8'h03);
      bus(ADDR_ORDER, 1'b1, 8'h03);
      msb <= 1'b0;
      reply <= 8'hb4;
      rc(ADDR_FLAGS, 8'h10, "overrun flag");
      bus(ADDR_FLAGS, 1'b1, 8'h00);
      wait_bytes(4);
      chk("lsb byte sent", got, 8'h48);
      repeat (24) @(posedge hclk);
      rc(ADDR_RXBUF, 8'hb4, "lsb byte received");
      $display("test overrun done");
      bus(ADDR_ROLE, 1'b1, 8'h86);
      cs_drv <= 1'b0;
      bus(ADDR_TXBUF, 1'b1, 8'h11);
      repeat (10) @(posedge hclk);
      chk("conflict irq", {7'h0, conf_irq}, 8'h01);
      rc(ADDR_ROLE, 8'h06, "master cleared");
      $display("test conflict done");
      sbyte(8'h6d, srx);
      rc(ADDR_RXBUF, 8'h6d, "slave byte received");
      chk("slave byte sent", srx, 8'h11);
      $display("test slave done");
      close_out();
   end
endmodule : ssp_top_tb
